// *** pkg/capture_regs.svh ***
`ifndef CAPTURE_REGS_SVH
`define CAPTURE_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CAP_CTRL_OFS        4'h0
`define CAP_STATUS_OFS      4'h4
`define CAP_COUNT_OFS       4'h8

// ****************************************************************
// field positions
// ****************************************************************
`define CAP_CTRL_ARM_BIT    0
`define CAP_CTRL_FORCE_BIT  1
`define CAP_CTRL_BYPASS_BIT 2
`define CAP_CTRL_GAP_EN_BIT 3
`define CAP_STAT_RUN_BIT    0
`define CAP_STAT_DONE_BIT   1
`define CAP_STAT_STORE_BIT  2
`define CAP_STAT_OVF_BIT    3

// ****************************************************************
// widths and reset values
// ****************************************************************
`define CAP_ADDR_W          4
`define CAP_DATA_W          32
`define CAP_SAMPLE_W        16
`define CAP_COUNT_W         16
`define CAP_BYPASS_RST      1'b0
`define CAP_GAP_EN_RST      1'b0

`endif

// *** pkg/capture_pkg.sv ***
`include "capture_regs.svh"

package capture_pkg;

    typedef enum logic [1:0] {
        MODE_CONTINUOUS,
        MODE_CONDITIONAL,
        MODE_START_STOP,
        MODE_STATE
    } qual_mode_e;

    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_RUN,
        CAP_DONE
    } cap_phase_e;

    typedef struct packed {
        logic                     gap;
        logic [`CAP_SAMPLE_W-1:0] data;
    } sample_s;

    typedef struct packed {
        logic start_cond;
        logic stop_cond;
        logic begin_store;
        logic halt_store;
        logic cond_true;
        logic trigger;
    } probe_s;

    typedef struct packed {
        cap_phase_e              phase;
        logic                    storing;
        logic                    stored_once;
        logic                    gap_pend;
        logic                    bypass;
        logic                    gap_en;
        logic                    overflow;
        logic [`CAP_COUNT_W-1:0] count;
        logic [`CAP_DATA_W-1:0]  rdata;
    } cap_st_s;

    typedef struct packed {
        sample_s head;
        sample_s tail;
        logic    head_v;
        logic    tail_v;
    } buf_st_s;

endpackage

// *** src/sample_skid_buffer.sv ***
`timescale 1ns/100ps

module sample_skid_buffer (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                in_valid,
    input  capture_pkg::sample_s     in_word,
    output logic                     in_ready,
    output logic                     out_valid,
    output capture_pkg::sample_s     out_word,
    input  wire logic                out_ready
);
    import capture_pkg::*;

    buf_st_s st_r;
    buf_st_s st_nxt;
    logic    pop;
    logic    push;

    // ****************************************************************
    // two entries: head feeds the output, tail absorbs one stall
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        pop    = st_r.head_v && out_ready;
        push   = in_valid && !st_r.tail_v;
        if (pop) begin
            st_nxt.head_v = st_r.tail_v;
            st_nxt.head   = st_r.tail;
            st_nxt.tail_v = 1'b0;
        end
        if (push) begin
            if (!st_nxt.head_v) begin
                st_nxt.head_v = 1'b1;
                st_nxt.head   = in_word;
            end else begin
                st_nxt.tail_v = 1'b1;
                st_nxt.tail   = in_word;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready  = !st_r.tail_v;
    assign out_valid = st_r.head_v;
    assign out_word  = st_r.head;

endmodule

// *** src/capture_storage_qualifier.sv ***
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "capture_regs.svh"

module capture_storage_qualifier #(
    parameter capture_pkg::qual_mode_e MODE = capture_pkg::MODE_START_STOP
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic [`CAP_ADDR_W-1:0] reg_addr,
    input  wire logic [`CAP_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`CAP_DATA_W-1:0] reg_rdata,
    input  capture_pkg::probe_s         probe,
    input  wire logic [`CAP_SAMPLE_W-1:0] sample_in,
    output logic                        out_valid,
    output capture_pkg::sample_s        out_word,
    input  wire logic                   out_ready
);
    import capture_pkg::*;

    cap_st_s  st_r;
    cap_st_s  st_nxt;
    logic     buf_ready;
    logic     wr_ctrl;
    logic     arm_req;
    logic     force_req;
    logic     running;
    logic     go_cond;
    logic     halt_cond;
    logic     want;
    logic     store;
    logic     missed;
    sample_s  word;

    // ****************************************************************
    // register decode
    // ****************************************************************
    function automatic logic addr_hit(input logic [`CAP_ADDR_W-1:0] a,
                                      input logic [`CAP_ADDR_W-1:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // ****************************************************************
    // qualifier and capture control
    // ****************************************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = '0;
        wr_ctrl      = reg_wr && addr_hit(reg_addr, `CAP_CTRL_OFS);
        arm_req      = wr_ctrl && reg_wdata[`CAP_CTRL_ARM_BIT];
        force_req    = wr_ctrl && reg_wdata[`CAP_CTRL_FORCE_BIT];
        running      = (st_r.phase == CAP_RUN);

        if (wr_ctrl) begin
            st_nxt.bypass = reg_wdata[`CAP_CTRL_BYPASS_BIT];
            st_nxt.gap_en = reg_wdata[`CAP_CTRL_GAP_EN_BIT];
        end

        // mode chosen at build time only
        case (MODE)
            MODE_START_STOP: begin
                go_cond   = probe.start_cond;
                halt_cond = probe.stop_cond;
            end
            MODE_STATE: begin
                go_cond   = probe.begin_store;
                halt_cond = probe.halt_store;
            end
            default: begin
                go_cond   = 1'b0;
                halt_cond = 1'b0;
            end
        endcase

        // the go cycle itself stores, even when halt comes with it
        case (MODE)
            MODE_CONTINUOUS:  want = 1'b1;
            MODE_CONDITIONAL: want = probe.cond_true;
            MODE_START_STOP:  want = st_r.storing || go_cond;
            MODE_STATE:       want = st_r.storing || go_cond;
            default:          want = 1'b0;
        endcase
        if (st_r.bypass) begin
            want = 1'b1;
        end
        want   = want && running;
        store  = want && buf_ready;
        missed = want && !buf_ready;

        word.gap  = st_r.gap_en && st_r.gap_pend;
        word.data = sample_in;

        if (running) begin
            if (halt_cond) begin
                st_nxt.storing = 1'b0;
            end else if (go_cond) begin
                st_nxt.storing = 1'b1;
            end
            if (store) begin
                st_nxt.count       = st_r.count + `CAP_COUNT_W'(1);
                st_nxt.gap_pend    = 1'b0;
                st_nxt.stored_once = 1'b1;
            end else if (st_r.stored_once || missed) begin
                st_nxt.gap_pend = 1'b1;
            end
            if (missed) begin
                st_nxt.overflow = 1'b1;
            end
            if (probe.trigger || force_req) begin
                st_nxt.phase   = CAP_DONE;
                st_nxt.storing = 1'b0;
            end
        end else if (arm_req) begin
            st_nxt.phase       = CAP_RUN;
            st_nxt.storing     = 1'b0;
            st_nxt.stored_once = 1'b0;
            st_nxt.gap_pend    = 1'b0;
            st_nxt.overflow    = 1'b0;
            st_nxt.count       = '0;
        end

        if (reg_rd) begin
            if (addr_hit(reg_addr, `CAP_CTRL_OFS)) begin
                st_nxt.rdata[`CAP_CTRL_BYPASS_BIT] = st_r.bypass;
                st_nxt.rdata[`CAP_CTRL_GAP_EN_BIT] = st_r.gap_en;
            end else if (addr_hit(reg_addr, `CAP_STATUS_OFS)) begin
                st_nxt.rdata[`CAP_STAT_RUN_BIT]   = running;
                st_nxt.rdata[`CAP_STAT_DONE_BIT]  = (st_r.phase == CAP_DONE);
                st_nxt.rdata[`CAP_STAT_STORE_BIT] = st_r.storing;
                st_nxt.rdata[`CAP_STAT_OVF_BIT]   = st_r.overflow;
            end else if (addr_hit(reg_addr, `CAP_COUNT_OFS)) begin
                st_nxt.rdata[`CAP_COUNT_W-1:0] = st_r.count;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r        <= '0;
            st_r.phase  <= CAP_IDLE;
            st_r.bypass <= `CAP_BYPASS_RST;
            st_r.gap_en <= `CAP_GAP_EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;

    // ****************************************************************
    // two-entry buffer toward the acquisition memory
    // ****************************************************************
    sample_skid_buffer u_buf (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (store),
        .in_word   (word),
        .in_ready  (buf_ready),
        .out_valid (out_valid),
        .out_word  (out_word),
        .out_ready (out_ready)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    a_start_begins:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_START_STOP && running && !st_r.bypass && !st_r.storing
         && probe.start_cond && !probe.stop_cond && !probe.trigger && !force_req)
        |-> want ##1 st_r.storing)
    else $error("start did not begin storing");

    a_stop_pauses:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_START_STOP && running && probe.stop_cond)
        |=> !st_r.storing)
    else $error("stop did not pause storing");

    a_start_ignored:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_START_STOP && running && st_r.storing && probe.start_cond
         && !probe.stop_cond && !probe.trigger && !force_req)
        |=> st_r.storing && running)
    else $error("repeated start disturbed storing");

    a_both_single:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_START_STOP && running && !st_r.bypass && !st_r.storing
         && probe.start_cond && probe.stop_cond && buf_ready)
        |-> store ##1 (!st_r.storing && st_r.count == $past(st_r.count) + 16'h1))
    else $error("start with stop did not store one sample");

    a_force_done:
    assert property (@(posedge clk) disable iff (reset)
        (running && force_req) |=> (st_r.phase == CAP_DONE) ##1 !store)
    else $error("force did not end acquisition");

    a_state_wait:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_STATE && running && !st_r.bypass && !st_r.storing
         && !probe.begin_store) |-> !store)
    else $error("stored before begin action");

    a_halt_pauses:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_STATE && running && !st_r.bypass && probe.halt_store
         && !probe.begin_store)
        ##1 (running && !probe.begin_store) |-> !store)
    else $error("halt did not pause writes");

    a_both_actions:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_STATE && running && !st_r.bypass && !st_r.storing
         && probe.begin_store && probe.halt_store && buf_ready)
        |-> store ##1 !st_r.storing)
    else $error("begin with halt did not store one sample");

    a_gap_marked:
    assert property (@(posedge clk) disable iff (reset)
        (running && st_r.stored_once && st_r.gap_en && !store) ##1 store
        |-> word.gap)
    else $error("sample after pause not marked");

    a_bypass_all:
    assert property (@(posedge clk) disable iff (reset)
        (running && st_r.bypass && buf_ready && !probe.trigger && !force_req)
        |=> st_r.count == $past(st_r.count) + 16'h1)
    else $error("bypass did not store every cycle");

    a_trigger_ends:
    assert property (@(posedge clk) disable iff (reset)
        (running && probe.trigger) |=> (st_r.phase == CAP_DONE) [*2])
    else $error("trigger did not stop capture");

    a_cond_only:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_CONDITIONAL && !st_r.bypass && store) |-> probe.cond_true)
    else $error("conditional store without condition");

    a_gap_clear:
    assert property (@(posedge clk) disable iff (reset)
        (running && store && !probe.trigger && !force_req) |=> !st_r.gap_pend)
    else $error("gap flag not cleared after store");

    a_resume_start:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_START_STOP && running && !st_r.storing && probe.start_cond
         && !probe.stop_cond && !probe.trigger && !force_req)
        ##1 (running && !probe.stop_cond && !probe.trigger && buf_ready) |-> store)
    else $error("start did not resume storing");

    a_idle_quiet:
    assert property (@(posedge clk) disable iff (reset)
        !running |-> !store)
    else $error("stored outside a run");

    a_done_holds:
    assert property (@(posedge clk) disable iff (reset)
        (st_r.phase == CAP_DONE && !arm_req) |=> (st_r.phase == CAP_DONE))
    else $error("capture left done without arm");

    a_trig_last:
    assert property (@(posedge clk) disable iff (reset)
        (running && probe.trigger) |=> !store)
    else $error("stored after trigger");

    a_cont_every:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_CONTINUOUS && running && buf_ready) |-> store)
    else $error("continuous mode skipped a cycle");

    a_arm_clears:
    assert property (@(posedge clk) disable iff (reset)
        (!running && arm_req)
        |=> (running && !st_r.storing && st_r.count == '0 && !st_r.gap_pend))
    else $error("arm did not start a clean run");

    a_begin_starts:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_STATE && running && probe.begin_store && !probe.halt_store
         && !probe.trigger && !force_req) |=> st_r.storing)
    else $error("begin action did not start storing");

    a_halt_stored:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_STATE && running && st_r.storing && probe.halt_store && buf_ready)
        |-> store ##1 !st_r.storing)
    else $error("halt cycle not stored or storing kept");

    a_pause_holds:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_START_STOP && running && !st_r.bypass && !st_r.storing
         && !probe.start_cond) |-> !store)
    else $error("stored while paused");

    a_stop_stored:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_START_STOP && running && st_r.storing && probe.stop_cond
         && buf_ready) |-> store)
    else $error("stop cycle not stored");

    a_count_step:
    assert property (@(posedge clk) disable iff (reset)
        store |=> (st_r.count == $past(st_r.count) + 16'h1))
    else $error("count did not follow a store");

    a_cond_stores:
    assert property (@(posedge clk) disable iff (reset)
        (MODE == MODE_CONDITIONAL && running && probe.cond_true && buf_ready) |-> store)
    else $error("true condition not stored");

    a_gap_set:
    assert property (@(posedge clk) disable iff (reset)
        (running && st_r.stored_once && !store) |=> st_r.gap_pend)
    else $error("pause not remembered");

    a_first_clean:
    assert property (@(posedge clk) disable iff (reset)
        (store && !st_r.stored_once && !st_r.overflow) |-> !word.gap)
    else $error("first sample marked as gap");

    a_loss_marks:
    assert property (@(posedge clk) disable iff (reset)
        missed |=> (st_r.gap_pend && st_r.overflow))
    else $error("lost sample not remembered");

    a_bypass_set:
    assert property (@(posedge clk) disable iff (reset)
        (wr_ctrl && reg_wdata[`CAP_CTRL_BYPASS_BIT]) |=> st_r.bypass)
    else $error("bypass write not taken");

endmodule

// *** verification/capture_sink.sv ***
`timescale 1ns/100ps

// ****************************************************************
// consumer of the stored word stream
// ****************************************************************
module capture_sink (
    input  wire logic             clk,
    input  wire logic             stall,
    input  wire logic             out_valid,
    input  capture_pkg::sample_s  out_word,
    output logic                  out_ready
);
    import capture_pkg::*;

    sample_s words[$];

    // stall holds ready low so the buffer must keep its words
    assign out_ready = !stall;

    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            words.push_back(out_word);
        end
    end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`include "capture_regs.svh"

module testbench;
    import capture_pkg::*;

    localparam logic [5:0] P_START = 6'h20;
    localparam logic [5:0] P_STOP  = 6'h10;
    localparam logic [5:0] P_TRIG  = 6'h01;
    localparam logic [5:0] P_BEGIN = 6'h08;
    localparam logic [5:0] P_HALT  = 6'h04;
    localparam logic [5:0] P_COND  = 6'h02;

    logic                     clk         = 1'b0;
    logic                     reset       = 1'b1;
    logic [`CAP_ADDR_W-1:0]   reg_addr    = '0;
    logic [`CAP_DATA_W-1:0]   reg_wdata   = '0;
    logic                     reg_wr      = 1'b0;
    logic                     reg_rd      = 1'b0;
    logic [`CAP_DATA_W-1:0]   reg_rdata;
    logic [`CAP_DATA_W-1:0]   rdata_state;
    logic [`CAP_DATA_W-1:0]   rdata_cond;
    logic [`CAP_DATA_W-1:0]   rdata_cont;
    probe_s                   probe       = '0;
    logic [`CAP_SAMPLE_W-1:0] sample_in   = '0;
    logic                     out_valid;
    sample_s                  out_word;
    logic                     out_ready;
    logic                     stall       = 1'b0;
    int                       err_total   = 0;
    int                       check_count = 0;
    int                       cycles      = 0;

    always #25 clk = ~clk;

    // monitored data: a running count shows which cycles were stored
    always @(posedge clk) begin
        sample_in <= sample_in + 16'h1;
    end

    capture_storage_qualifier #(.MODE(MODE_START_STOP)) u_dut (
        .clk       (clk),
        .reset     (reset),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .probe     (probe),
        .sample_in (sample_in),
        .out_valid (out_valid),
        .out_word  (out_word),
        .out_ready (out_ready)
    );

    capture_storage_qualifier #(.MODE(MODE_STATE)) u_dut_state (
        .clk       (clk),
        .reset     (reset),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (rdata_state),
        .probe     (probe),
        .sample_in (sample_in),
        .out_valid (),
        .out_word  (),
        .out_ready (1'b1)
    );

    capture_storage_qualifier #(.MODE(MODE_CONDITIONAL)) u_dut_cond (
        .clk       (clk),
        .reset     (reset),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (rdata_cond),
        .probe     (probe),
        .sample_in (sample_in),
        .out_valid (),
        .out_word  (),
        .out_ready (1'b1)
    );

    capture_storage_qualifier #(.MODE(MODE_CONTINUOUS)) u_dut_cont (
        .clk       (clk),
        .reset     (reset),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (rdata_cont),
        .probe     (probe),
        .sample_in (sample_in),
        .out_valid (),
        .out_word  (),
        .out_ready (1'b1)
    );

    capture_sink u_sink (
        .clk       (clk),
        .stall     (stall),
        .out_valid (out_valid),
        .out_word  (out_word),
        .out_ready (out_ready)
    );

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge clk);
    endtask

    // one read checked on the state, conditional and continuous instances
    task automatic rd_modes(input logic [3:0] a, input logic [31:0] e_st,
                            input logic [31:0] e_cd, input logic [31:0] e_ct);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata_state, e_st);
        chk(rdata_cond, e_cd);
        chk(rdata_cont, e_ct);
        @(posedge clk);
    endtask

    // probe pattern p for n cycles, leaves it applied
    task automatic go(input logic [5:0] p, input int n);
        repeat (n) begin
            probe <= p;
            @(posedge clk);
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        chk({31'h0, out_valid}, 32'h0);
        rd_chk(`CAP_CTRL_OFS, 32'h0);
        rd_chk(`CAP_STATUS_OFS, 32'h0);
        rd_chk(`CAP_COUNT_OFS, 32'h0);
        rd_chk(4'hc, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_start_stop();
        int base;
        base = u_sink.words.size();
        wr_reg(`CAP_CTRL_OFS, 32'h1);
        go(6'h0, 2);
        go(P_START, 1);
        go(6'h0, 1);
        go(P_START, 1);
        go(6'h0, 2);
        go(P_STOP, 1);
        go(6'h0, 3);
        rd_chk(`CAP_COUNT_OFS, 32'd6);
        rd_chk(`CAP_STATUS_OFS, 32'h1);
        go(P_START | P_STOP, 1);
        go(6'h0, 3);
        rd_chk(`CAP_COUNT_OFS, 32'd7);
        go(P_START, 1);
        go(6'h0, 2);
        go(P_STOP, 1);
        go(6'h0, 2);
        rd_chk(`CAP_COUNT_OFS, 32'd11);
        chk(u_sink.words.size() - base, 32'd11);
        go(P_TRIG, 1);
        go(6'h0, 1);
        rd_chk(`CAP_STATUS_OFS, 32'h2);
        $display("start stop test done");
    endtask

    task automatic t_force();
        wr_reg(`CAP_CTRL_OFS, 32'h1);
        go(P_START, 1);
        go(P_STOP, 1);
        go(6'h0, 2);
        wr_reg(`CAP_CTRL_OFS, 32'h2);
        go(P_START, 2);
        go(6'h0, 2);
        rd_chk(`CAP_STATUS_OFS, 32'h2);
        rd_chk(`CAP_COUNT_OFS, 32'd2);
        $display("force test done");
    endtask

    task automatic t_gap();
        int base;
        base = u_sink.words.size();
        wr_reg(`CAP_CTRL_OFS, 32'h9);
        go(P_START, 1);
        go(P_STOP, 1);
        go(6'h0, 2);
        go(P_START, 1);
        go(P_STOP, 1);
        go(6'h0, 4);
        chk(u_sink.words.size() - base, 32'd4);
        for (int i = 0; i < 4; i++) begin
            chk({31'h0, u_sink.words[base + i].gap}, {31'h0, i == 2});
        end
        chk(u_sink.words[base + 2].data - u_sink.words[base + 1].data, 32'd3);
        go(P_TRIG, 1);
        go(6'h0, 1);
        $display("gap test done");
    endtask

    task automatic t_bypass();
        wr_reg(`CAP_CTRL_OFS, 32'h5);
        go(6'h0, 5);
        go(P_TRIG, 1);
        go(6'h0, 3);
        rd_chk(`CAP_COUNT_OFS, 32'd6);
        rd_chk(`CAP_STATUS_OFS, 32'h2);
        $display("bypass test done");
    endtask

    task automatic t_overflow();
        int base;
        base = u_sink.words.size();
        stall <= 1'b1;
        wr_reg(`CAP_CTRL_OFS, 32'h5);
        go(6'h0, 4);
        go(P_TRIG, 1);
        go(6'h0, 2);
        rd_chk(`CAP_STATUS_OFS, 32'ha);
        rd_chk(`CAP_COUNT_OFS, 32'd2);
        stall <= 1'b0;
        go(6'h0, 4);
        chk(u_sink.words.size() - base, 32'd2);
        chk({31'h0, out_valid}, 32'h0);
        $display("overflow test done");
    endtask

    task automatic t_modes();
        wr_reg(`CAP_CTRL_OFS, 32'h1);
        go(6'h0, 2);
        go(P_COND, 2);
        go(6'h0, 1);
        rd_modes(`CAP_COUNT_OFS, 32'd0, 32'd2, 32'd5);
        go(P_BEGIN, 1);
        go(6'h0, 2);
        go(P_HALT, 1);
        go(P_COND, 2);
        go(6'h0, 1);
        rd_modes(`CAP_COUNT_OFS, 32'd4, 32'd4, 32'd14);
        go(P_BEGIN | P_HALT, 1);
        go(6'h0, 2);
        rd_modes(`CAP_COUNT_OFS, 32'd5, 32'd4, 32'd19);
        rd_modes(`CAP_STATUS_OFS, 32'h1, 32'h1, 32'h1);
        go(P_TRIG, 1);
        go(6'h0, 1);
        rd_modes(`CAP_COUNT_OFS, 32'd5, 32'd4, 32'd24);
        rd_modes(`CAP_STATUS_OFS, 32'h2, 32'h2, 32'h2);
        $display("modes test done");
    endtask

    // ****************************************************************
    // hang guard and main sequence
    // ****************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            $display("ERROR %0t: run did not finish", $time);
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_start_stop();
        t_force();
        t_gap();
        t_bypass();
        t_overflow();
        t_modes();
        give_verdict();
    end
endmodule
